// ==== common/pss_pkg.sv ====
/*
 * Shared constants and types for the pipelined synchronous SRAM port.
 * Assumes a single rising-edge clock domain and a separate storage array.
 */
package pss_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int CNT_W = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0_0000_0000;
    // Strap level that selects the linear order.
    localparam logic ORDER_LINEAR = 1'b0;

    // Selected state of the port.
    typedef enum logic {
        PSS_DESEL,
        PSS_ACTIVE
    } pss_state_t;
endpackage : pss_pkg

// ==== hw/pss_burst_cnt.sv ====
/*
 * Two-bit wraparound burst counter with linear and interleaved orders.
 * Assumes load and step are never asked for in the same cycle by the parent.
 */
`timescale 1ns/10ps
module pss_burst_cnt
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [CNT_W-1:0] start_lo,
    input wire logic step,
    input wire logic interleave,
    output logic [CNT_W-1:0] lo_cur,
    output logic [CNT_W-1:0] lo_adv
);
    logic [CNT_W-1:0] base_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_nxt;

    // The counter wraps by its width, so a burst returns to its first word.
    assign cnt_nxt = cnt_q + CNT_ONE;

    // Interleaved order XORs the step count; linear order adds it modulo four.
    assign lo_cur = interleave ? (base_q ^ cnt_q) : (base_q + cnt_q);
    assign lo_adv = interleave ? (base_q ^ cnt_nxt) : (base_q + cnt_nxt);

    // A strobe reloads the start bits; an advance steps the count.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            base_q <= CNT_ZERO;
            cnt_q <= CNT_ZERO;
        end else if (load) begin
            base_q <= start_lo;
            cnt_q <= CNT_ZERO;
        end else if (step) begin
            cnt_q <= cnt_nxt;
        end
    end
endmodule : pss_burst_cnt

// ==== hw/pss_port.sv ====
/*
 * Control side of a pipelined synchronous burst SRAM port with common data I/O.
 * Assumes an external storage array that answers mem_rdata combinationally from
 * mem_addr_q, and a testbench that resolves the data wire from dq_oe.
 */
// Function
// - Second chip select, active high, sampled.
// - Third select active low; all three select.
// - Output enable low drives, high floats.
// - First read after deselect keeps pins floating.
// - Advance low steps burst address.
// - Processor strobe loads address and counter.
// - Processor strobe ignored while first select high.
// - Controller strobe loads address and counter.
// - Both strobes low: processor strobe wins.
// - Sleep input high idles, contents kept.
// - Input data captured on rising edge.
// - Read data from previous edge's address.
// - Strap low linear, high interleaved.
// - Interleaved: start bits XOR step count.
// - Two-bit counter wraps after four.
// - Write cycle floats data pins always.
// - First chip select active low, sampled.
`timescale 1ns/10ps
module pss_port
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic global_write_n,
    input wire logic byte_wr_enable_n,
    input wire logic [LANES-1:0] byte_lane_sel_n,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic burst_order,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic [DATA_W-1:0] mem_rdata,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [LANES-1:0] mem_lanes,
    output logic [DATA_W-1:0] mem_wdata
);
    pss_state_t state_q, state_d;
    logic mode_q;
    logic [ADDR_W-1:CNT_W] base_q;
    logic [DATA_W-1:0] dq_out_q;
    logic dq_oe_q, dq_oe_d;
    logic [ADDR_W-1:0] mem_addr_q, mem_addr_d;
    logic mem_rd_q, mem_wr_q;
    logic [LANES-1:0] mem_lanes_q, mem_lanes_d;
    logic [DATA_W-1:0] mem_wdata_q;
    logic [CNT_W-1:0] lo_cur, lo_adv;

    // Select decode and strobe arbitration.
    wire sel_w = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
    wire proc_take_w = !proc_addr_strobe_n && !chip_sel_first_n;
    wire ctrl_take_w = !ctrl_addr_strobe_n && !proc_take_w;
    wire strobe_w = proc_take_w || ctrl_take_w;
    wire go_w = strobe_w && sel_w && !sleep_request;
    wire desel_w = strobe_w && !sel_w && !sleep_request;
    wire cont_w = (state_q == PSS_ACTIVE) && !strobe_w && !sleep_request;
    wire adv_w = cont_w && !burst_step_n;
    wire first_w = go_w && (state_q == PSS_DESEL);
    wire interleave_w = (mode_q != ORDER_LINEAR);

    // Write qualification: a global write takes every lane, else the chosen ones.
    wire wr_req_w = !global_write_n || (!byte_wr_enable_n && (byte_lane_sel_n != LANES_ALL));
    // A processor-strobe start ignores the write inputs in its first cycle.
    wire wr_now_w = wr_req_w && ((ctrl_take_w && go_w) || cont_w);
    wire rd_now_w = (go_w || cont_w) && !wr_now_w;

    assign mem_lanes_d = !global_write_n ? LANES_ALL : ~byte_lane_sel_n;
    assign mem_addr_d = go_w ? addr : (adv_w ? {base_q, lo_adv} : {base_q, lo_cur});
    assign state_d = go_w ? PSS_ACTIVE : (desel_w ? PSS_DESEL : state_q);
    // The driver follows the enable only while selected, never on the first
    // cycle out of deselect, never on a write and never asleep.
    assign dq_oe_d = (state_d == PSS_ACTIVE) && !out_en_n && !first_w && !wr_now_w && !sleep_request;

    pss_burst_cnt u_cnt (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .load(go_w),
        .start_lo(addr[CNT_W-1:0]),
        .step(adv_w),
        .interleave(interleave_w),
        .lo_cur(lo_cur),
        .lo_adv(lo_adv)
    );

    // Access state, strap sample and address base; sleep freezes state and base, but the strap is still sampled on every edge.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= PSS_DESEL;
            mode_q <= ORDER_LINEAR;
            base_q <= ADDR_ZERO[ADDR_W-1:CNT_W];
        end else begin
            state_q <= state_d;
            mode_q <= burst_order;
            if (go_w) begin
                base_q <= addr[ADDR_W-1:CNT_W];
            end
        end
    end

    // Array command stage; write data is taken from the pins on every edge.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mem_addr_q <= ADDR_ZERO;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            mem_lanes_q <= LANES_NONE;
            mem_wdata_q <= DATA_ZERO;
        end else begin
            mem_addr_q <= mem_addr_d;
            mem_rd_q <= rd_now_w;
            mem_wr_q <= wr_now_w;
            mem_lanes_q <= mem_lanes_d;
            mem_wdata_q <= dq_in;
        end
    end

    // Output pipeline stage: one edge after the array address, data reaches the pins.
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dq_out_q <= DATA_ZERO;
            dq_oe_q <= 1'b0;
        end else begin
            if (mem_rd_q) begin
                dq_out_q <= mem_rdata;
            end
            dq_oe_q <= dq_oe_d;
        end
    end

    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;
    assign mem_addr = mem_addr_q;
    assign mem_rd = mem_rd_q;
    assign mem_wr = mem_wr_q;
    assign mem_lanes = mem_lanes_q;
    assign mem_wdata = mem_wdata_q;

    // Checks on the port behaviour, all in the one clock domain.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_desel;
        strobe_w && !sel_w && !sleep_request |=> state_q == PSS_DESEL && !dq_oe_q;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect did not float");

    property p_oe_high;
        out_en_n |=> !dq_oe_q;
    endproperty
    a_oe_high: assert property (p_oe_high) else $error("driving with enable high");

    property p_first_mask;
        go_w && state_q == PSS_DESEL |=> !dq_oe_q;
    endproperty
    a_first_mask: assert property (p_first_mask) else $error("first read cycle not floated");

    property p_proc_load;
        !proc_addr_strobe_n && sel_w && !sleep_request |=> mem_addr_q == $past(addr) && mem_rd_q && !mem_wr_q;
    endproperty
    a_proc_load: assert property (p_proc_load) else $error("processor strobe load wrong");

    // Checked from an active burst as well, where a wrongly honoured strobe would show up as a deselect.
    property p_proc_ignored;
        chip_sel_first_n && ctrl_addr_strobe_n
            |=> state_q == $past(state_q) && ($past(state_q) == PSS_ACTIVE || (!mem_rd_q && !mem_wr_q));
    endproperty
    a_proc_ignored: assert property (p_proc_ignored) else $error("processor strobe not ignored");

    property p_ctrl_write;
        !ctrl_addr_strobe_n && proc_addr_strobe_n && sel_w && !sleep_request && wr_req_w
            |=> mem_wr_q && mem_addr_q == $past(addr) && mem_wdata_q == $past(dq_in);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("controller write wrong");

    property p_sleep;
        sleep_request |=> !mem_wr_q && !mem_rd_q && !dq_oe_q && state_q == $past(state_q);
    endproperty
    a_sleep: assert property (p_sleep) else $error("activity during sleep");

    property p_pipe;
        mem_rd_q |=> dq_out_q == $past(mem_rdata);
    endproperty
    a_pipe: assert property (p_pipe) else $error("read data not pipelined");

    property p_interleave;
        go_w && interleave_w ##1 adv_w && interleave_w |=> mem_addr_q[1:0] == ($past(addr[1:0], 2) ^ CNT_ONE);
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleaved step wrong");

    property p_linear;
        go_w && !interleave_w ##1 adv_w && !interleave_w |=> mem_addr_q[1:0] == $past(addr[1:0], 2) + CNT_ONE;
    endproperty
    a_linear: assert property (p_linear) else $error("linear step wrong");

    property p_wrap;
        go_w ##1 adv_w [*4] |=> mem_addr_q == $past(addr, 5);
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst did not wrap");

    property p_wr_float;
        wr_now_w |=> !dq_oe_q;
    endproperty
    a_wr_float: assert property (p_wr_float) else $error("driving on write");
endmodule : pss_port

// ==== verif/pss_mem_model.sv ====
/* Behavioural storage array standing behind the SRAM port, written lane by lane.
   Assumes the port presents one beat per clock and reads the array combinationally. */
`timescale 1ns/10ps
module pss_mem_model
    import pss_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_wr,
    input wire logic [LANES-1:0] mem_lanes,
    input wire logic [DATA_W-1:0] mem_wdata,
    output logic [DATA_W-1:0] mem_rdata
);
    logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

    // Each word starts as a pattern of its own address, so a wrong address shows up as wrong data.
    initial begin
        for (int a = 0; a < (1 << ADDR_W); a++) begin
            cells[a] = {6'h2A, ADDR_W'(a), ~ADDR_W'(a)};
        end
    end

    // Only enabled lanes change; the rest of the word must survive a partial write.
    always @(posedge ref_clk) begin
        for (int l = 0; l < LANES; l++) begin
            if (mem_wr && mem_lanes[l]) begin
                cells[mem_addr][l*LANE_W +: LANE_W] <= mem_wdata[l*LANE_W +: LANE_W];
            end
        end
    end

    // Read data follows the address with no clock.
    assign mem_rdata = cells[mem_addr];
endmodule : pss_mem_model

// ==== verif/tb_top.sv ====
/* Self-checking bench for the SRAM port: writes, bursts in both orders, strobe priority, refusals.
   Assumes the array model beside the port; inputs change at the falling clock edge. */
`timescale 1ns/10ps
module tb_top;
    import pss_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, chip_sel_first_n = 1'b0, chip_sel_second = 1'b0, chip_sel_third_n = 1'b0;
    logic proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_step_n = 1'b1, global_write_n = 1'b1;
    logic byte_wr_enable_n = 1'b1, out_en_n = 1'b1, sleep_request = 1'b0, burst_order = 1'b0;
    logic [LANES-1:0] byte_lane_sel_n = LANES_ALL;
    logic [ADDR_W-1:0] addr = ADDR_ZERO;
    logic [DATA_W-1:0] tb_dq = DATA_ZERO;
    logic [DATA_W-1:0] dq_in, mem_rdata, dq_out, mem_wdata;
    logic [ADDR_W-1:0] mem_addr;
    logic [LANES-1:0] mem_lanes;
    logic dq_oe, mem_rd, mem_wr;
    int n_fail = 0, checks_done = 0;

    // The data wire: the port's drivers win while enabled, else the bench's write data.
    assign dq_in = dq_oe ? dq_out : tb_dq;

    pss_port DUT (.ref_clk, .nrst, .addr, .chip_sel_first_n, .chip_sel_second, .chip_sel_third_n,
        .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .global_write_n, .byte_wr_enable_n,
        .byte_lane_sel_n, .out_en_n, .sleep_request, .burst_order, .dq_in, .mem_rdata, .dq_out,
        .dq_oe, .mem_addr, .mem_rd, .mem_wr, .mem_lanes, .mem_wdata);
    pss_mem_model mem_i (.ref_clk, .mem_addr, .mem_wr, .mem_lanes, .mem_wdata, .mem_rdata);

    // Free-running 100 MHz clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return {6'h2A, a, ~a};
    endfunction : pat

    // Deselect cycle; leaves the controller strobe low and selects ready for the caller to finish.
    task automatic desel();
        @(negedge ref_clk);
        {chip_sel_first_n, chip_sel_third_n, chip_sel_second, sleep_request} = 4'h0;
        {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, burst_step_n} = 4'hB;
        @(negedge ref_clk);
        chk(mem_rd | mem_wr, 1'b0);
        chk(dq_oe, 1'b0);
    endtask : desel

    // Global write by controller strobe, held for a second beat with the output enable low.
    task automatic wr_ctrl();
        desel();
        addr = 15'h0300;
        chip_sel_second = 1'b1;
        global_write_n = 1'b0;
        out_en_n = 1'b0;
        tb_dq = 36'h9_8765_4321;
        @(negedge ref_clk);
        chk(mem_wr, 1'b1);
        chk(mem_addr, 15'h0300);
        chk(mem_lanes, LANES_ALL);
        chk(mem_wdata, 36'h9_8765_4321);
        ctrl_addr_strobe_n = 1'b1;
        @(negedge ref_clk);
        chk(dq_oe, 1'b0);
        out_en_n = 1'b1;
    endtask : wr_ctrl

    // Read burst of four steps, the fourth wrapping to the start, in the order given by the strap.
    task automatic burst(input logic [ADDR_W-1:0] a, input logic ord);
        logic [ADDR_W-1:0] cur;
        logic [ADDR_W-1:0] prev;
        burst_order = ord;
        desel();
        addr = a;
        chip_sel_second = 1'b1;
        out_en_n = 1'b0;
        @(negedge ref_clk);
        chk(mem_rd, 1'b1);
        chk(mem_addr, a);
        chk(dq_oe, 1'b0);
        ctrl_addr_strobe_n = 1'b1;
        burst_step_n = 1'b0;
        prev = a;
        for (int i = 1; i <= 4; i++) begin
            cur = a;
            cur[1:0] = ord ? (a[1:0] ^ CNT_W'(i)) : (a[1:0] + CNT_W'(i));
            @(negedge ref_clk);
            chk(mem_addr, cur);
            chk(dq_out, pat(prev));
            chk(dq_oe, 1'b1);
            prev = cur;
        end
        burst_step_n = 1'b1;
        out_en_n = 1'b1;
        @(negedge ref_clk);
        chk(dq_oe, 1'b0);
    endtask : burst

    // Both strobes low with the global write low: the processor strobe wins and starts a read.
    task automatic both_strobes();
        desel();
        addr = 15'h0555;
        chip_sel_second = 1'b1;
        proc_addr_strobe_n = 1'b0;
        global_write_n = 1'b0;
        @(negedge ref_clk);
        chk(mem_rd, 1'b1);
        chk(mem_wr, 1'b0);
        chk(mem_addr, 15'h0555);
        // A processor strobe under a high first select must neither deselect nor restart: the burst goes on.
        chip_sel_first_n = 1'b1;
        ctrl_addr_strobe_n = 1'b1;
        global_write_n = 1'b1;
        @(negedge ref_clk);
        chk(mem_rd, 1'b1);
        chk(mem_addr, 15'h0555);
    endtask : both_strobes

    // Processor-strobe start, byte write of lanes 0 and 2 on the second beat, then the word is read back.
    task automatic wr_proc_bytes();
        desel();
        addr = 15'h0ACE;
        chip_sel_second = 1'b1;
        ctrl_addr_strobe_n = 1'b1;
        proc_addr_strobe_n = 1'b0;
        byte_wr_enable_n = 1'b0;
        byte_lane_sel_n = 4'hA;
        out_en_n = 1'b0;
        tb_dq = 36'h1_2345_6789;
        @(negedge ref_clk);
        chk(mem_rd, 1'b1);
        chk(mem_wr, 1'b0);
        chk(dq_oe, 1'b0);
        proc_addr_strobe_n = 1'b1;
        @(negedge ref_clk);
        chk(mem_wr, 1'b1);
        chk(mem_addr, 15'h0ACE);
        chk(mem_lanes, 4'h5);
        chk(mem_wdata, 36'h1_2345_6789);
        chk(dq_oe, 1'b0);
        byte_wr_enable_n = 1'b1;
        byte_lane_sel_n = LANES_ALL;
        ctrl_addr_strobe_n = 1'b0;
        @(negedge ref_clk);
        chk(mem_rd, 1'b1);
        ctrl_addr_strobe_n = 1'b1;
        @(negedge ref_clk);
        chk(dq_out, (pat(15'h0ACE) & 36'hF_F803_FE00) | (36'h1_2345_6789 & 36'h0_07FC_01FF));
        chk(dq_oe, 1'b1);
        out_en_n = 1'b1;
    endtask : wr_proc_bytes

    // Strobes that must start nothing: first select high, third select high, sleep.
    task automatic refused();
        for (int i = 0; i < 4; i++) begin
            desel();
            chip_sel_second = 1'b1;
            chip_sel_first_n = (i < 2);
            chip_sel_third_n = (i == 2);
            sleep_request = (i == 3);
            proc_addr_strobe_n = (i != 0);
            ctrl_addr_strobe_n = (i == 0);
            @(negedge ref_clk);
            chk(mem_rd | mem_wr, 1'b0);
        end
    endtask : refused

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // Every wait above is a fixed cycle count, so the sequence cannot hang.
    initial begin
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        wr_ctrl();
        burst(15'h1235, 1'b0);
        burst(15'h4ABE, 1'b1);
        both_strobes();
        wr_proc_bytes();
        refused();
        results();
    end
endmodule : tb_top
